// File: verilog/amp_pkg.sv
// Constants and types for the amplifier mode and fault manager
package amp_pkg;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;

  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] REG_PWR = 8'h01;
  localparam logic [7:0] REG_DIG2 = 8'h03;
  localparam logic [7:0] REG_VOL = 8'h04;
  localparam logic [7:0] REG_FAULT = 8'h08;
  localparam logic [7:0] REG_DIG3 = 8'h13;
  localparam logic [7:0] REG_ANA2 = 8'h14;
  localparam logic [7:0] PWR_RST = 8'hFD;
  localparam logic [7:0] DIG2_RST = 8'h80;
  localparam logic [7:0] VOL_RST = 8'hCF;
  localparam logic [1:0] OC_LVL_RST = 2'h0;
  localparam logic [7:0] DIG3_RST = 8'h00;
  localparam logic [7:0] ANA2_RST = 8'h02;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned PWR_SHUT_BIT = 0;
  localparam int unsigned PWR_SLEEP_BIT = 1;
  localparam int unsigned DIG2_MUTE_BIT = 4;
  localparam int unsigned DIG2_SPEED_BIT = 6;
  localparam int unsigned DIG3_AUTO_LSB = 3;
  localparam int unsigned ANA2_PU_BIT = 3;
  localparam int unsigned FLT_OC_LSB = 4;

  // ----------------------------------------
  // Volume ramp: 0.5 dB steps from -100 dB
  // ----------------------------------------
  localparam logic [7:0] RAMP_LVL_MAX = 8'hC8;
  localparam logic [3:0] RAMP_DIV_SLOW = 4'hF;
  localparam logic [3:0] RAMP_DIV_FAST = 4'h1;

  // ----------------------------------------
  // Auto sleep idle-sample counts
  // ----------------------------------------
  localparam logic [14:0] AUTO_N1 = 15'h1000;
  localparam logic [14:0] AUTO_N2 = 15'h2000;
  localparam logic [14:0] AUTO_N3 = 15'h4000;

  // ----------------------------------------
  // Times and cycle counts
  // ----------------------------------------
  localparam int unsigned T_ACTIVE_NS = 1000;
  localparam int unsigned T_PULSE_NS = 10000;
  localparam int unsigned T_PERIOD_NS = 350000;
  localparam int unsigned T_DC_MS = 650;
  localparam int unsigned T_LONG_MS = 1300;
  localparam int unsigned START_CYC = (T_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_CYC = T_PULSE_NS / CLK_NS;
  localparam int unsigned PERIOD_CYC = T_PERIOD_NS / CLK_NS;
  localparam int unsigned DC_WAIT_CYC = T_DC_MS * (1000000 / CLK_NS);
  localparam int unsigned LONG_WAIT_CYC = T_LONG_MS * (1000000 / CLK_NS);

  typedef enum logic [2:0] {
    ST_SHUT, ST_START, ST_UP, ST_ACT, ST_DOWN, ST_MUTE, ST_SLEEP
  } mode_e;

endpackage : amp_pkg

// File: verilog/ramp_if.sv
// Volume ramp control and status bundle
`timescale 1ns/1ps
interface ramp_if;
  logic [7:0] target;
  logic fast;
  logic step;
  logic clear;
  logic [7:0] level;
  logic at_target;
  modport ctrl (output target, fast, step, clear, input level, at_target);
  modport gen (input target, fast, step, clear, output level, at_target);
endinterface : ramp_if

// File: verilog/vol_ramp.sv
// Sample-paced volume ramp generator
`timescale 1ns/1ps
module vol_ramp (
  input wire logic clk,
  input wire logic rstn,
  ramp_if.gen rp
);
  import amp_pkg::*;

  logic [3:0] div_q;
  logic [7:0] level_q;
  logic [3:0] div_top;

  assign div_top = rp.fast ? RAMP_DIV_FAST : RAMP_DIV_SLOW;
  assign rp.level = level_q;
  assign rp.at_target = (level_q == rp.target);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 4'h0;
      level_q <= 8'h00;
    end else if (rp.clear) begin
      div_q <= 4'h0;
      level_q <= 8'h00;
    end else if (rp.step) begin
      if (rp.at_target) begin
        div_q <= 4'h0;
      end else if (div_q == div_top) begin
        div_q <= 4'h0;
        if (level_q < rp.target) begin
          level_q <= level_q + 8'h01;
        end else begin
          level_q <= level_q - 8'h01;
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

endmodule : vol_ramp

// File: verilog/fault_pin.sv
// Open-drain fault pin driver with startup pulsing
`timescale 1ns/1ps
module fault_pin #(
  parameter int unsigned PERIOD = amp_pkg::PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hold_low,
  input wire logic pulse_req,
  output logic fault_n_out_o,
  output logic fault_n_out_oe
);
  import amp_pkg::*;

  logic [12:0] cnt_q;
  logic drive_q;

  assign fault_n_out_o = 1'b0;
  assign fault_n_out_oe = drive_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 13'h0;
    end else if (!pulse_req || cnt_q == 13'(PERIOD - 1)) begin
      cnt_q <= 13'h0;
    end else begin
      cnt_q <= cnt_q + 13'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= hold_low | (pulse_req & (cnt_q < 13'(PULSE_CYC)));
    end
  end

endmodule : fault_pin

// File: verilog/amp_mode_fault_manager.sv
// Mode sequencer and fault supervisor for a mono class-D amplifier
`timescale 1ns/1ps
module amp_mode_fault_manager #(
  parameter int unsigned PERIOD = amp_pkg::PERIOD_CYC,
  parameter int unsigned DC_WAIT = amp_pkg::DC_WAIT_CYC,
  parameter int unsigned LONG_WAIT = amp_pkg::LONG_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic shutdown_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_stb,
  input wire logic sample_zero,
  input wire logic pvdd_fault,
  input wire logic clk_fault,
  input wire logic over_temp_det,
  input wire logic dc_det,
  input wire logic over_current_det,
  output logic [1:0] current_limit_level,
  output amp_pkg::mode_e mode,
  output logic analog_on,
  output logic switching_en,
  output logic out_hiz,
  output logic idle_input,
  output logic [7:0] vol_level,
  output logic fault_n_out_o,
  output logic fault_n_out_oe,
  output logic fault_pullup_en
);
  import amp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] pwr_q, dig2_q, vol_q, dig3_q, ana2_q;
  logic [1:0] oc_lvl_q;
  logic over_temp_flag, dc_offset_flag, over_current_flag;
  logic clock_error_flag;
  logic [24:0] rec_q;
  logic [14:0] zcnt_q;
  logic [7:0] start_q;
  logic been_active_q, auto_q;
  logic sw_q, idle_q;
  logic [7:0] rdata_q;
  mode_e st_q, st_d, dest_q, dest_d;
  logic shut_req, sleep_bit, mute_bit, latched, rec_busy;
  logic clk_flt, fault_sleep, auto_hit, start_done;
  logic [7:0] vol_tgt;
  ramp_if ramp ();

  function automatic logic is_switching(input mode_e m);
    return (m == ST_UP) || (m == ST_ACT) || (m == ST_DOWN) ||
           (m == ST_MUTE);
  endfunction : is_switching

  function automatic logic [14:0] auto_limit(input logic [1:0] c);
    case (c)
      2'h1: return AUTO_N1;
      2'h2: return AUTO_N2;
      default: return AUTO_N3;
    endcase
  endfunction : auto_limit

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= PWR_RST;
      dig2_q <= DIG2_RST;
      vol_q <= VOL_RST;
      oc_lvl_q <= OC_LVL_RST;
      dig3_q <= DIG3_RST;
      ana2_q <= ANA2_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_PWR: pwr_q <= reg_wdata;
        REG_DIG2: dig2_q <= reg_wdata;
        REG_VOL: vol_q <= reg_wdata;
        REG_FAULT: oc_lvl_q <= reg_wdata[FLT_OC_LSB +: 2];
        REG_DIG3: dig3_q <= reg_wdata;
        REG_ANA2: ana2_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Shutdown reads the clock flag as set
  assign clock_error_flag = (st_q == ST_SHUT) | clk_flt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        REG_PWR: rdata_q <= pwr_q;
        REG_DIG2: rdata_q <= dig2_q;
        REG_VOL: rdata_q <= vol_q;
        REG_FAULT: rdata_q <= {2'h0, oc_lvl_q, clock_error_flag,
          over_current_flag, dc_offset_flag, over_temp_flag};
        REG_DIG3: rdata_q <= dig3_q;
        REG_ANA2: rdata_q <= ana2_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign current_limit_level = oc_lvl_q;
  assign fault_pullup_en = ana2_q[ANA2_PU_BIT];

  // ----------------------------------------
  // Requests and fault qualification
  // ----------------------------------------
  assign shut_req = !shutdown_n | !pwr_q[PWR_SHUT_BIT];
  assign sleep_bit = pwr_q[PWR_SLEEP_BIT];
  assign mute_bit = dig2_q[DIG2_MUTE_BIT];
  assign clk_flt = clk_fault & (st_q != ST_SHUT);
  assign latched = over_temp_flag | dc_offset_flag | over_current_flag;
  assign rec_busy = (rec_q != 25'h0);
  assign fault_sleep = pvdd_fault | clk_flt | latched | rec_busy;
  assign auto_hit = (dig3_q[DIG3_AUTO_LSB +: 2] != 2'h0) &&
    (zcnt_q >= auto_limit(dig3_q[DIG3_AUTO_LSB +: 2]));
  assign start_done = (start_q == 8'(START_CYC - 1));
  assign vol_tgt = (vol_q > RAMP_LVL_MAX) ? RAMP_LVL_MAX : vol_q;

  // ----------------------------------------
  // Latched flags: set wins over clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      over_temp_flag <= 1'b0;
      dc_offset_flag <= 1'b0;
      over_current_flag <= 1'b0;
    end else begin
      over_temp_flag <= over_temp_det | (over_temp_flag & !shut_req);
      dc_offset_flag <= dc_det | (dc_offset_flag & !shut_req);
      over_current_flag <= over_current_det |
        (over_current_flag & !shut_req);
    end
  end

  // ----------------------------------------
  // Recovery wait after a cleared flag
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rec_q <= 25'h0;
    end else if (shut_req && (over_temp_flag || over_current_flag)) begin
      rec_q <= 25'(LONG_WAIT);
    end else if (shut_req && dc_offset_flag) begin
      rec_q <= 25'(DC_WAIT);
    end else if (rec_busy) begin
      rec_q <= rec_q - 25'h1;
    end
  end

  // ----------------------------------------
  // Idle sample counter and start delay
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zcnt_q <= 15'h0;
    end else if (sample_stb) begin
      if (!sample_zero) begin
        zcnt_q <= 15'h0;
      end else if (zcnt_q != 15'h7FFF) begin
        zcnt_q <= zcnt_q + 15'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 8'h00;
    end else if (st_q == ST_START && !start_done) begin
      start_q <= start_q + 8'h01;
    end else begin
      start_q <= 8'h00;
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    dest_d = dest_q;
    if (shut_req && st_q != ST_SHUT) begin
      if (is_switching(st_q) && vol_level != 8'h00 && !fault_sleep) begin
        st_d = ST_DOWN;
        dest_d = ST_SHUT;
      end else begin
        st_d = ST_SHUT;
      end
    end else begin
      case (st_q)
        ST_SHUT: begin
          if (!shut_req) begin
            st_d = ST_START;
          end
        end
        ST_START: begin
          if (start_done) begin
            st_d = (fault_sleep || sleep_bit) ? ST_SLEEP : ST_UP;
          end
        end
        ST_UP: begin
          if (fault_sleep) begin
            st_d = ST_SLEEP;
          end else if (sleep_bit) begin
            st_d = ST_DOWN;
            dest_d = ST_SLEEP;
          end else if (ramp.at_target) begin
            st_d = mute_bit ? ST_MUTE : ST_ACT;
          end
        end
        ST_ACT: begin
          if (fault_sleep || auto_hit) begin
            st_d = ST_SLEEP;
          end else if (sleep_bit) begin
            st_d = ST_DOWN;
            dest_d = ST_SLEEP;
          end else if (mute_bit) begin
            st_d = ST_DOWN;
            dest_d = ST_MUTE;
          end
        end
        ST_DOWN: begin
          if (fault_sleep) begin
            st_d = ST_SLEEP;
          end else if (ramp.at_target) begin
            st_d = dest_q;
          end
        end
        ST_MUTE: begin
          if (fault_sleep || sleep_bit) begin
            st_d = ST_SLEEP;
          end else if (!mute_bit) begin
            st_d = ST_UP;
          end
        end
        ST_SLEEP: begin
          if (!(fault_sleep || sleep_bit || auto_hit)) begin
            st_d = auto_q ? ST_ACT : ST_UP;
          end
        end
        default: st_d = ST_SHUT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_SHUT;
      dest_q <= ST_SHUT;
    end else begin
      st_q <= st_d;
      dest_q <= dest_d;
    end
  end

  // Auto sleep keeps the volume, so wake needs no ramp
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auto_q <= 1'b0;
    end else if (st_q == ST_ACT) begin
      auto_q <= auto_hit & !fault_sleep & !shut_req;
    end else if (st_q != ST_SLEEP || fault_sleep || sleep_bit) begin
      auto_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      been_active_q <= 1'b0;
    end else if (st_q == ST_SHUT) begin
      been_active_q <= 1'b0;
    end else if (st_q == ST_ACT) begin
      been_active_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Power stage outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      sw_q <= is_switching(st_d);
      idle_q <= (st_d == ST_MUTE);
    end
  end

  assign mode = st_q;
  assign switching_en = sw_q;
  assign out_hiz = !sw_q;
  assign idle_input = idle_q;
  assign analog_on = (st_q != ST_SHUT);

  // ----------------------------------------
  // Volume ramp
  // ----------------------------------------
  assign ramp.target = ((st_q == ST_UP || st_q == ST_ACT || auto_q) &&
    !mute_bit) ? vol_tgt : 8'h00;
  assign ramp.fast = dig2_q[DIG2_SPEED_BIT];
  assign ramp.step = sample_stb;
  assign ramp.clear = (st_q == ST_SHUT) || (st_q == ST_SLEEP && !auto_q);
  assign vol_level = ramp.level;

  vol_ramp u_ramp (
    .clk(clk),
    .rstn(rstn),
    .rp(ramp.gen)
  );

  // ----------------------------------------
  // Fault pin
  // ----------------------------------------
  fault_pin #(.PERIOD(PERIOD)) u_fpin (
    .clk(clk),
    .rstn(rstn),
    .hold_low(latched | rec_busy | (clk_flt & been_active_q)),
    .pulse_req(clk_flt & !been_active_q),
    .fault_n_out_o(fault_n_out_o),
    .fault_n_out_oe(fault_n_out_oe)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [4:0] sc_q;
  logic [7:0] lvl_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sc_q <= 5'h0;
      lvl_q <= 8'h00;
    end else begin
      lvl_q <= vol_level;
      if (ramp.clear || (sample_stb && ramp.at_target)) begin
        sc_q <= 5'h0;
      end else if (vol_level != lvl_q) begin
        sc_q <= {4'h0, sample_stb};
      end else if (sample_stb && sc_q != 5'h1F) begin
        sc_q <= sc_q + 5'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_sleep;
    st_q == ST_SLEEP |-> !switching_en && analog_on && out_hiz;
  endproperty
  a_sleep: assert property (p_sleep) else $error("switching in sleep");

  property p_start;
    st_q == ST_START && start_done && !shut_req && !fault_sleep &&
      !sleep_bit |=> st_q == ST_UP && vol_level == 8'h00 && switching_en;
  endproperty
  a_start: assert property (p_start) else $error("bad wake start");

  property p_step;
    $changed(vol_level) && !$past(ramp.clear) |->
      $past(sample_stb) && ($past(sc_q) == ($past(ramp.fast) ? 5'h1 : 5'hF));
  endproperty
  a_step: assert property (p_step) else $error("ramp pace wrong");

  property p_auto;
    st_q == ST_ACT && auto_hit && !fault_sleep && !shut_req |=>
      st_q == ST_SLEEP && $stable(vol_level);
  endproperty
  a_auto: assert property (p_auto) else $error("auto sleep wrong");

  property p_mute;
    st_q == ST_MUTE |-> switching_en && idle_input && vol_level == 8'h00;
  endproperty
  a_mute: assert property (p_mute) else $error("mute state wrong");

  property p_shut;
    st_q == ST_SHUT |-> out_hiz && !analog_on ##1 st_q != ST_ACT;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown leaks");

  property p_clk;
    is_switching(st_q) && clk_fault && !shut_req |=> st_q == ST_SLEEP;
  endproperty
  a_clk: assert property (p_clk) else $error("clock fault slow");

  property p_clock_error_flag;
    st_q == ST_SHUT && reg_addr == REG_FAULT |=> reg_rdata[3];
  endproperty
  a_clock_error_flag: assert property (p_clock_error_flag) else $error("clock flag low");

  property p_hold;
    over_temp_flag && !shut_req |=> over_temp_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");

  property p_pin;
    latched |=> fault_n_out_oe ##1 fault_n_out_oe || shut_req;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not low");

  property p_rec;
    rec_busy |=> fault_n_out_oe && st_q != ST_ACT;
  endproperty
  a_rec: assert property (p_rec) else $error("early recovery");

  c_active: cover property (st_q == ST_UP ##1 st_q == ST_ACT);
  c_auto: cover property (st_q == ST_ACT ##1 st_q == ST_SLEEP && auto_q);
  c_recover: cover property (rec_q == 25'h1);
  c_mute: cover property (st_q == ST_DOWN ##1 st_q == ST_MUTE);

endmodule : amp_mode_fault_manager

// File: tb/host_model.sv
// Host controller model: shutdown pin and register writes
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic shutdown_n,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    shutdown_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One byte write; callers keep reserved bits at defaults, except the 8'hFF write to the fault register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #2;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic sel(input logic [7:0] a);
    @(posedge clk) #2;
    reg_addr = a;
    @(posedge clk);
  endtask : sel

  // Sets the shutdown pin level; low clears latched flags, high restarts the mode sequencer from shutdown
  task automatic pin(input logic v);
    @(posedge clk) #2;
    shutdown_n = v;
  endtask : pin
endmodule : host_model

// File: tb/amp_mode_fault_manager_test.sv
// Self-checking bench for the amplifier mode and fault manager
`timescale 1ns/1ps
module amp_mode_fault_manager_test;
  import amp_pkg::*;
  typedef struct {int k; logic [7:0] v;} note_s;
  logic clk = 1'b0;
  logic rstn, sample_stb, sample_zero, pvdd_fault, clk_fault;
  logic run, quiet, shutdown_n, reg_wr;
  logic [2:0] det;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vol_level;
  logic [1:0] current_limit_level;
  mode_e mode;
  logic analog_on, switching_en, out_hiz, idle_input;
  logic fault_n_out_o, fault_n_out_oe, fault_pullup_en;
  logic [31:0] seed = 32'h52B3;
  note_s q[$];
  note_s e;
  int miscompares = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_done = 0;
  int waited, cyc = 0;
  string nm[10] = '{"reg_rdata", "mode", "fault_pin", "switching_en",
    "vol_level", "idle_input", "wait_len", "pullup", "limit", "analog_on"};

  always #25 clk = ~clk;

  host_model host_u (.clk(clk), .shutdown_n(shutdown_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  amp_mode_fault_manager #(.DC_WAIT(50), .LONG_WAIT(100))
  dut_u (.clk(clk), .rstn(rstn), .shutdown_n(shutdown_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_stb(sample_stb), .sample_zero(sample_zero),
    .pvdd_fault(pvdd_fault), .clk_fault(clk_fault),
    .over_temp_det(det[0]), .dc_det(det[1]), .over_current_det(det[2]),
    .current_limit_level(current_limit_level), .mode(mode),
    .analog_on(analog_on), .switching_en(switching_en), .out_hiz(out_hiz),
    .idle_input(idle_input), .vol_level(vol_level),
    .fault_n_out_o(fault_n_out_o), .fault_n_out_oe(fault_n_out_oe),
    .fault_pullup_en(fault_pullup_en));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] seen(input int k);
    case (k)
      0: return reg_rdata;
      1: return {5'h00, mode};
      2: return {6'h00, fault_n_out_o, fault_n_out_oe};
      3: return {6'h00, out_hiz, switching_en};
      4: return vol_level;
      5: return {7'h00, idle_input};
      8: return {6'h00, current_limit_level};
      default: return {7'h00, analog_on};
    endcase
  endfunction : seen

  task automatic cmp_byte(input int k, input logic [7:0] x,
                          input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm[k], x, g);
      miscompares++;
    end
  endtask : cmp_byte

  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic expect_val(input int k, input logic [7:0] v);
    q.push_back('{k, v});
    n_req++;
  endtask : expect_val

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    host_u.sel(a);
    expect_val(0, v);
  endtask : rd

  task automatic want_mode(input mode_e m);
    waited = 0;
    while (mode !== m && waited < 20000) begin
      @(posedge clk);
      waited++;
    end
    expect_val(1, {5'h00, m});
  endtask : want_mode

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(negedge clk) begin
    while (n_done < n_req) begin
      e = q.pop_front();
      n_done++;
      cmp_byte(e.k, e.v, seen(e.k));
    end
  end

  // Sample strobes every other cycle, random content
  always @(posedge clk) begin
    #2;
    sample_stb = run & ~sample_stb;
    sample_zero = quiet | (seed[0] & seed[1]);
    seed = lfsr(seed);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    det = 3'h0;
    pvdd_fault = 1'b0;
    clk_fault = 1'b0;
    run = 1'b0;
    quiet = 1'b0;
    sample_stb = 1'b0;
    sample_zero = 1'b0;
    repeat (8) @(posedge clk);
    #2 rstn = 1'b1;
    rd(8'h08, 8'h08);
    rd(8'h01, 8'hFD);
    expect_val(1, {5'h00, ST_SHUT});
    expect_val(9, 8'h00);
    host_u.wr(8'h03, 8'hC0);
    host_u.wr(8'h14, 8'h0A);
    cmp_byte(7, 8'h01, {7'h00, fault_pullup_en});
    run = 1'b1;
    host_u.pin(1'b1);
    repeat (20) @(posedge clk);
    expect_val(1, {5'h00, ST_START});
    expect_val(3, 8'h02);
    @(posedge clk);
    expect_val(1, {5'h00, ST_UP});
    expect_val(3, 8'h01);
    want_mode(ST_ACT);
    cmp_byte(6, 8'd8, 8'((waited + 50) / 100));
    expect_val(4, 8'hC8);
    host_u.wr(8'h03, 8'hD0);
    want_mode(ST_MUTE);
    expect_val(5, 8'h01);
    expect_val(3, 8'h01);
    host_u.wr(8'h03, 8'hC0);
    want_mode(ST_ACT);
    host_u.wr(8'h01, 8'hFF);
    want_mode(ST_SLEEP);
    expect_val(3, 8'h02);
    expect_val(9, 8'h01);
    host_u.wr(8'h01, 8'hFD);
    want_mode(ST_ACT);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk) #2 det = 3'h1 << f;
      @(posedge clk) #2 det = 3'h0;
      want_mode(ST_SLEEP);
      rd(8'h08, 8'h01 << f);
      expect_val(2, 8'h01);
      repeat (20) @(posedge clk);
      rd(8'h08, 8'h01 << f);
      host_u.pin(1'b0);
      repeat (2) @(posedge clk);
      host_u.pin(1'b1);
      repeat (75) @(posedge clk);
      expect_val(2, {7'h00, f != 1});
      rd(8'h08, 8'h00);
      rd(8'h03, 8'hC0);
      want_mode(ST_ACT);
      expect_val(2, 8'h00);
    end
    @(posedge clk) #2 clk_fault = 1'b1;
    @(posedge clk);
    @(posedge clk);
    expect_val(1, {5'h00, ST_SLEEP});
    for (int i = 0; i < 4; i++) begin
      repeat (70) @(posedge clk);
      expect_val(2, 8'h01);
    end
    rd(8'h08, 8'h08);
    #2 clk_fault = 1'b0;
    want_mode(ST_ACT);
    #2 pvdd_fault = 1'b1;
    want_mode(ST_SLEEP);
    rd(8'h08, 8'h00);
    #2 pvdd_fault = 1'b0;
    want_mode(ST_ACT);
    host_u.wr(8'h13, 8'h08);
    quiet = 1'b1;
    want_mode(ST_SLEEP);
    cmp_byte(6, 8'd8, 8'(waited / 1000));
    expect_val(4, 8'hC8);
    quiet = 1'b0;
    want_mode(ST_ACT);
    expect_val(3, 8'h01);
    host_u.wr(8'h08, 8'hFF);
    rd(8'h08, 8'h30);
    expect_val(8, 8'h03);
    rd(8'h55, 8'h00);
    host_u.pin(1'b0);
    @(posedge clk) #2 rstn = 1'b0;
    @(posedge clk) #2 rstn = 1'b1;
    rd(8'h14, 8'h02);
    rd(8'h08, 8'h08);
    @(posedge clk) #2 clk_fault = 1'b1;
    host_u.pin(1'b1);
    repeat (100) @(posedge clk);
    expect_val(2, 8'h01);
    repeat (150) @(posedge clk);
    expect_val(2, 8'h00);
    expect_val(1, {5'h00, ST_SLEEP});
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule : amp_mode_fault_manager_test
